/* File: sbi_core.sv */
// The register offsets and the Wishbone register port are this design's own decisions.
`timescale 1ns/10ps
module sbi_core import sbi_pkg::*; #(
	parameter int DEPTH = FIFO_DEPTH,
	parameter int WIDTH = WORD_W
) (
	// system
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// wishbone slave
	input  wire logic [31:0] wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic        wb_we_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// serial link
	input  wire logic        sck_i,
	input  wire logic        ss_n_i,
	input  wire logic        sdi_i,
	output logic             sdo_o,
	output logic             sdo_oe_o,
	output logic             sdi_owned_o,
	// interrupts
	output logic             tx_irq_o,
	output logic             rx_irq_o,
	output logic             irq_o
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam int BIT_W = $clog2(WIDTH);
	localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
	localparam logic [CNT_W-1:0] HALF_CNT = CNT_W'(DEPTH / 2);
	localparam logic [BIT_W-1:0] LAST_BIT = BIT_W'(WIDTH - 1);

	sbi_ctrl_t        ctrl_q;
	logic [IRQ_W-1:0] irq_st_q;
	logic [IRQ_W-1:0] irq_en_q;
	logic             ack_q;
	logic [31:0]      dat_q;
	logic [WIDTH-1:0] tx_mem [DEPTH];
	logic [WIDTH-1:0] rx_mem [DEPTH];
	logic [PTR_W-1:0] tx_wr_q, tx_rd_q, rx_wr_q, rx_rd_q;
	logic [CNT_W-1:0] tx_cnt_q, rx_cnt_q;
	sbi_sh_state_t    sh_q;
	logic [BIT_W-1:0] bit_cnt_q;
	logic [WIDTH-1:0] tx_sh_q, rx_sh_q;
	logic             sck_prev_q;
	logic             sdo_q, sdo_oe_q, sdi_own_q, tx_irq_q, rx_irq_q, irq_q;
	sbi_link_t        link_raw, link_s;
	logic             req, wr, rd, sel_ctrl, sel_data;
	logic             tx_push, tx_pop, rx_push, rx_pop, rx_ovf;
	logic             pol_eff, sck_n, lead, trail, frame_act, in_bit, busy;
	logic             tx_cond, rx_cond;
	logic [31:0]      wmask, ctrl_word, ctrl_new;
	logic [WIDTH-1:0] rx_word;

	// ==========================================
	// pin synchroniser
	assign link_raw = '{sck: sck_i, ss_n: ss_n_i, sdi: sdi_i};

	sbi_sync #(.W(SYNC_W)) u_sync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.d_i     (link_raw),
		.q_o     (link_s)
	);

	// ==========================================
	// bus decode; a request is taken once, ack follows one cycle later
	assign req      = wb_cyc_i && wb_stb_i && !ack_q;
	assign wr       = req && wb_we_i;
	assign rd       = req && !wb_we_i;
	assign sel_ctrl = (wb_adr_i[4:0] == ADR_CTRL);
	assign sel_data = (wb_adr_i[4:0] == ADR_DATA);
	assign wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	// control register as a bus word
	always_comb
	begin
		ctrl_word = 32'h0000_0000;
		ctrl_word[CTL_FRM_BIT] = ctrl_q.framed_mode_enable;
		ctrl_word[CTL_ON_BIT]  = ctrl_q.on;
		ctrl_word[CTL_AUD_BIT] = ctrl_q.audio_protocol_enable;
		ctrl_word[CTL_POL_BIT] = ctrl_q.clock_polarity;
		ctrl_word[CTL_DIS_BIT] = ctrl_q.input_pin_disable;
		ctrl_word[CTL_TXS_LSB +: 2] = ctrl_q.tx_irq_select;
		ctrl_word[CTL_RXS_LSB +: 2] = ctrl_q.rx_irq_select;
		ctrl_new = (ctrl_word & ~wmask) | (wb_dat_i & wmask);
	end

	// control writes
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			ctrl_q <= CTRL_RST;
		else if (wr && sel_ctrl)
		begin
			ctrl_q.on                <= ctrl_new[CTL_ON_BIT];
			ctrl_q.input_pin_disable <= ctrl_new[CTL_DIS_BIT];
			ctrl_q.tx_irq_select     <= ctrl_new[CTL_TXS_LSB +: 2];
			ctrl_q.rx_irq_select     <= ctrl_new[CTL_RXS_LSB +: 2];
			if (!ctrl_q.on)
			begin
				ctrl_q.framed_mode_enable    <= ctrl_new[CTL_FRM_BIT];
				ctrl_q.audio_protocol_enable <= ctrl_new[CTL_AUD_BIT];
				ctrl_q.clock_polarity        <= ctrl_new[CTL_POL_BIT];
			end
		end
	end

	// read mux and ack; unmapped offsets read zero and still ack
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end
		else
		begin
			ack_q <= req;
			dat_q <= 32'h0000_0000;
			if (rd)
			begin
				case (wb_adr_i[4:0])
					ADR_CTRL:   dat_q <= ctrl_word;
					ADR_DATA:   dat_q <= 32'(rx_mem[rx_rd_q]);
					ADR_STAT:
					begin
						dat_q[STAT_BUSY_BIT]           <= busy;
						dat_q[STAT_TXC_LSB +: CNT_W]   <= tx_cnt_q;
						dat_q[STAT_RXC_LSB +: CNT_W]   <= rx_cnt_q;
					end
					ADR_IRQ_ST: dat_q <= 32'(irq_st_q);
					ADR_IRQ_EN: dat_q <= 32'(irq_en_q);
					default:    dat_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ==========================================
	// buffers; a push to a full tx buffer is dropped, rx overflow is flagged
	assign tx_push = wr && sel_data && wb_sel_i[0] && (tx_cnt_q != FULL_CNT) && ctrl_q.on;
	assign rx_pop  = rd && sel_data && (rx_cnt_q != '0);
	assign rx_ovf  = rx_push && (rx_cnt_q == FULL_CNT);

	always_ff @(posedge clk_sys)
	begin
		if (tx_push)
			tx_mem[tx_wr_q] <= wb_dat_i[WIDTH-1:0];
		if (rx_push && !rx_ovf)
			rx_mem[rx_wr_q] <= rx_word;
	end

	// pointers and counts; switching off flushes both buffers
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n || !ctrl_q.on)
		begin
			tx_wr_q  <= '0;
			tx_rd_q  <= '0;
			tx_cnt_q <= '0;
			rx_wr_q  <= '0;
			rx_rd_q  <= '0;
			rx_cnt_q <= '0;
		end
		else
		begin
			tx_wr_q  <= tx_wr_q + PTR_W'(tx_push);
			tx_rd_q  <= tx_rd_q + PTR_W'(tx_pop);
			tx_cnt_q <= tx_cnt_q + CNT_W'(tx_push) - CNT_W'(tx_pop);
			rx_wr_q  <= rx_wr_q + PTR_W'(rx_push && !rx_ovf);
			rx_rd_q  <= rx_rd_q + PTR_W'(rx_pop);
			rx_cnt_q <= rx_cnt_q + CNT_W'(rx_push && !rx_ovf) - CNT_W'(rx_pop);
		end
	end

	// ==========================================
	// link edges
	// audio forces polarity
	assign pol_eff = ctrl_q.clock_polarity || ctrl_q.audio_protocol_enable;
	assign sck_n   = link_s.sck ^ pol_eff;
	assign lead    = sck_n && !(sck_prev_q ^ pol_eff);
	assign trail   = !sck_n && (sck_prev_q ^ pol_eff);
	assign frame_act = ctrl_q.on && (ctrl_q.framed_mode_enable || !link_s.ss_n);
	assign in_bit  = ctrl_q.input_pin_disable ? 1'b0 : link_s.sdi;
	assign rx_word = {rx_sh_q[WIDTH-2:0], in_bit};
	assign busy    = (sh_q == SH_ACTIVE);
	assign tx_pop  = (sh_q == SH_IDLE) && frame_act && (tx_cnt_q != '0);
	assign rx_push = busy && frame_act && lead && (bit_cnt_q == LAST_BIT);

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			sck_prev_q <= 1'b0;
		else
			sck_prev_q <= link_s.sck;
	end

	// shifter: loads a word (or zeros when starved), counts lead edges
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n || !ctrl_q.on)
		begin
			sh_q      <= SH_IDLE;
			bit_cnt_q <= '0;
			tx_sh_q   <= '0;
			rx_sh_q   <= '0;
		end
		else
		begin
			case (sh_q)
				SH_IDLE:
				begin
					bit_cnt_q <= '0;
					if (frame_act)
					begin
						tx_sh_q <= (tx_cnt_q != '0) ? tx_mem[tx_rd_q] : '0;
						sh_q    <= SH_ACTIVE;
					end
				end
				SH_ACTIVE:
				begin
					if (!frame_act)
						sh_q <= SH_IDLE;
					else if (lead)
					begin
						rx_sh_q   <= rx_word;
						bit_cnt_q <= bit_cnt_q + BIT_W'(1);
						if (bit_cnt_q == LAST_BIT)
							sh_q <= SH_IDLE;
					end
					else if (trail)
						tx_sh_q <= {tx_sh_q[WIDTH-2:0], 1'b0};
				end
				default: sh_q <= SH_IDLE;
			endcase
		end
	end

	// pin drivers; data out lags the shifter by one system cycle, far inside a link half period
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			sdo_q     <= 1'b0;
			sdo_oe_q  <= 1'b0;
			sdi_own_q <= 1'b0;
		end
		else
		begin
			sdo_q     <= tx_sh_q[WIDTH-1];
			sdo_oe_q  <= frame_act;
			sdi_own_q <= !ctrl_q.input_pin_disable;
		end
	end

	// ==========================================
	// interrupt conditions
	// continuous evaluation
	always_comb
	begin
		case (ctrl_q.tx_irq_select)
			SEL_3:   tx_cond = (tx_cnt_q != FULL_CNT);
			SEL_2:   tx_cond = (tx_cnt_q <= FULL_CNT - HALF_CNT);
			// empty, or empty and shifter done
			SEL_1:   tx_cond = (tx_cnt_q == '0);
			default: tx_cond = (tx_cnt_q == '0) && !busy;
		endcase
		case (ctrl_q.rx_irq_select)
			SEL_3:   rx_cond = (rx_cnt_q == FULL_CNT);
			SEL_2:   rx_cond = (rx_cnt_q >= HALF_CNT);
			// not empty, or last word read
			SEL_1:   rx_cond = (rx_cnt_q != '0);
			default: rx_cond = rx_pop && (rx_cnt_q == CNT_W'(1));
		endcase
	end

	// sticky status, enable and line; a set in the clearing cycle wins
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			irq_st_q <= IRQ_RST;
			irq_en_q <= IRQ_RST;
			tx_irq_q <= 1'b0;
			rx_irq_q <= 1'b0;
			irq_q    <= 1'b0;
		end
		else
		begin
			irq_st_q <= (irq_st_q & ~((wr && wb_adr_i[4:0] == ADR_IRQ_CLR) ? wb_dat_i[IRQ_W-1:0] : IRQ_RST))
				| {rx_ovf, rx_cond && ctrl_q.on, tx_cond && ctrl_q.on};
			if (wr && wb_adr_i[4:0] == ADR_IRQ_EN)
				irq_en_q <= wb_dat_i[IRQ_W-1:0];
			tx_irq_q <= tx_cond && ctrl_q.on;
			rx_irq_q <= rx_cond && ctrl_q.on;
			irq_q    <= |(irq_st_q & irq_en_q);
		end
	end

	assign wb_ack_o    = ack_q;
	assign wb_dat_o    = dat_q;
	assign sdo_o       = sdo_q;
	assign sdo_oe_o    = sdo_oe_q;
	assign sdi_owned_o = sdi_own_q;
	assign tx_irq_o    = tx_irq_q;
	assign rx_irq_o    = rx_irq_q;
	assign irq_o       = irq_q;

	// ==========================================
	// checks
	chk_sdi_ignored: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(busy && lead && frame_act && ctrl_q.input_pin_disable) |=> !rx_sh_q[0])
		else $error("serial input used while disabled");
	chk_tx_any_free: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(ctrl_q.on && ctrl_q.tx_irq_select == SEL_3 && tx_cnt_q != FULL_CNT) |=> tx_irq_q)
		else $error("tx request missing with free slot");
	chk_tx_empty_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(ctrl_q.tx_irq_select == SEL_1 && tx_cnt_q != '0) |=> !tx_irq_q)
		else $error("tx request while buffer not empty");
	chk_rx_full_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(ctrl_q.on && ctrl_q.rx_irq_select == SEL_3) |=> (rx_irq_q == ($past(rx_cnt_q) == FULL_CNT)))
		else $error("rx full request wrong");
	chk_rx_last_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(ctrl_q.on && ctrl_q.rx_irq_select == SEL_0 && !rx_pop) |=> !rx_irq_q)
		else $error("rx request without final read");
	chk_lock_held: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(wr && sel_ctrl && ctrl_q.on) |=> $stable(ctrl_q.clock_polarity) && $stable(ctrl_q.framed_mode_enable))
		else $error("locked bit changed while on");
	chk_audio_pol: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ctrl_q.audio_protocol_enable |-> (sck_n == !link_s.sck))
		else $error("audio mode not using polarity one");
	chk_irq_line: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(|(irq_st_q & irq_en_q)) |=> irq_q [*1] ##1 (irq_q || !$past(|(irq_st_q & irq_en_q))))
		else $error("interrupt line not raised");
endmodule

/* File: sbi_core_test.sv */
`timescale 1ns/10ps
// ==========================================
// bench for the serial port block
module sbi_core_test import sbi_pkg::*;;
	// framed runs set no other control bit than on
	localparam logic [31:0] FRM = 32'h8000_0000;
	localparam logic [31:0] ON = 32'h0000_8000;
	localparam logic [31:0] POL = 32'h0000_0040;
	localparam logic [31:0] AUD = 32'h0000_0080;
	logic        clk_sys, rst_n, cyc, stb, we, ack, sck, ss_n, sdi, sdo, oe, own, txi, rxi, irq;
	logic [31:0] adr, dat, dat_o, rd, rnd;
	logic [7:0]  w, got;
	logic [7:0]  sent [4];
	int          bad_count, checks, seen, pulses;

	// 250 MHz system clock
	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	sbi_core dut (.clk_sys(clk_sys), .rst_n(rst_n), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hF),
		.wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_o), .wb_ack_o(ack), .sck_i(sck),
		.ss_n_i(ss_n), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(oe), .sdi_owned_o(own), .tx_irq_o(txi),
		.rx_irq_o(rxi), .irq_o(irq));
	sbi_peer peer (.sck(sck), .ss_n(ss_n), .sdi(sdi), .sdo(sdo), .sdo_oe(oe));

	// counts receive request pulses; the main sequence only reads the count
	always @(posedge clk_sys)
		if (rxi === 1'b1)
			pulses <= pulses + 1;

	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", s, e, g);
		end
	endtask

	// classic cycle; an idle cycle always follows, so no access right after switching off
	task automatic wb(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		adr <= {27'h0, a};
		dat <= d;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1)
			chk("ack", 1, 0);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	// expected tx request from select and tx occupancy, shifter idle
	function automatic logic tx_exp(input logic [1:0] s, input int n);
		case (s)
			SEL_3: return n < FIFO_DEPTH;
			SEL_2: return n <= FIFO_DEPTH / 2;
			default: return n == 0;
		endcase
	endfunction

	// expected rx level request from select and rx occupancy
	function automatic logic rx_exp(input logic [1:0] s, input int n);
		case (s)
			SEL_3: return n == FIFO_DEPTH;
			SEL_2: return n >= FIFO_DEPTH / 2;
			SEL_1: return n > 0;
			default: return 1'b0;
		endcase
	endfunction

	task automatic results;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// watchdog: the whole run needs well under 100 us
	initial
	begin
		#200000;
		chk("watchdog", 0, 1);
		results;
	end

	// main sequence
	initial
	begin
		{rst_n, cyc, stb, we, adr, dat, seen} = '0;
		rnd = 48;
		bad_count = 0;
		checks = 0;
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		idle(2);
		wb(0, ADR_CTRL, 0);
		chk("ctrl", 0, rd);
		wb(0, 5'h1C, 0);
		chk("unmapped", 0, rd);
		chk("own", 1, own);
		wb(1, ADR_CTRL, 32'h10);
		idle(2);
		chk("own", 0, own);
		wb(1, ADR_CTRL, 0);
		idle(2);
		chk("own", 1, own);
		$display("test pin_owner done");
		// locked bits; the value stored before a write decides
		wb(1, ADR_CTRL, ON | POL);
		wb(1, ADR_CTRL, ON | AUD);
		wb(0, ADR_CTRL, 0);
		chk("ctrl", ON | POL, rd);
		wb(1, ADR_CTRL, 0);
		wb(0, ADR_CTRL, 0);
		chk("ctrl", POL, rd);
		wb(1, ADR_CTRL, 0);
		wb(0, ADR_CTRL, 0);
		chk("ctrl", 0, rd);
		// framed mode ignores the select pin, so the frame is active at once
		wb(1, ADR_CTRL, FRM);
		wb(1, ADR_CTRL, FRM | ON);
		idle(4);
		chk("framed_oe", 1, oe);
		wb(1, ADR_CTRL, 0);
		wb(1, ADR_CTRL, 0);
		wb(0, ADR_CTRL, 0);
		chk("ctrl", 0, rd);
		$display("test lock done");
		// every tx select at every occupancy
		for (int n = 0; n <= FIFO_DEPTH; n++)
		begin
			wb(1, ADR_CTRL, 0);
			wb(1, ADR_CTRL, ON);
			for (int k = 0; k < n; k++)
			begin
				rnd = xs(rnd);
				wb(1, ADR_DATA, rnd);
			end
			wb(0, ADR_STAT, 0);
			chk("tx_count", n << STAT_TXC_LSB, rd);
			for (int s = 0; s < 4; s++)
			begin
				wb(1, ADR_CTRL, ON | (s << CTL_TXS_LSB));
				idle(2);
				chk("tx_irq", tx_exp(s, n), txi);
			end
		end
		$display("test tx_select done");
		// sticky status, enable mask, clear
		wb(1, ADR_CTRL, 0);
		wb(1, ADR_CTRL, ON | (SEL_1 << CTL_TXS_LSB));
		idle(2);
		chk("irq", 0, irq);
		wb(1, ADR_IRQ_EN, 1);
		wb(0, ADR_IRQ_EN, 0);
		chk("irq_en", 1, rd);
		idle(1);
		chk("irq", 1, irq);
		wb(0, ADR_IRQ_ST, 0);
		chk("irq_st", 1, rd[IRQ_TX_BIT]);
		wb(1, ADR_CTRL, 0);
		wb(1, ADR_IRQ_CLR, 7);
		wb(0, ADR_IRQ_ST, 0);
		chk("irq_st", 0, rd);
		idle(1);
		chk("irq", 0, irq);
		$display("test irq done");
		// rx selects while words arrive, fifth word overflows
		wb(1, ADR_CTRL, ON);
		for (int n = 1; n <= FIFO_DEPTH + 1; n++)
		begin
			rnd = xs(rnd);
			if (n <= FIFO_DEPTH)
				sent[n-1] = rnd[7:0];
			peer.xfer(0, rnd[7:0], got);
			chk("starved_sdo", 0, got);
			idle(10);
			for (int s = 1; s < 4; s++)
			begin
				wb(1, ADR_CTRL, ON | s);
				idle(2);
				chk("rx_irq", rx_exp(s, n > FIFO_DEPTH ? FIFO_DEPTH : n), rxi);
			end
		end
		wb(0, ADR_IRQ_ST, 0);
		chk("overflow", 1, rd[IRQ_OVF_BIT]);
		// select 00 pulses only on the read that empties
		wb(1, ADR_CTRL, ON);
		// the full level left by select 11 must drain before counting
		idle(2);
		for (int k = 0; k < FIFO_DEPTH; k++)
		begin
			seen = pulses;
			wb(0, ADR_DATA, 0);
			chk("rx_data", sent[k], rd[7:0]);
			idle(3);
			chk("rx_pulse", k == FIFO_DEPTH - 1, pulses - seen);
		end
		$display("test rx_select done");
		// disabled input: a word with set bits must arrive as zeros
		wb(1, ADR_CTRL, ON | 32'h10);
		rnd = xs(rnd);
		peer.xfer(0, rnd[7:0] | 8'h81, got);
		idle(10);
		wb(0, ADR_DATA, 0);
		chk("rx_disabled", 0, rd[7:0]);
		$display("test input_disable done");
		// audio forces falling lead edge with polarity bit 0
		wb(1, ADR_CTRL, 0);
		wb(1, ADR_CTRL, AUD);
		wb(1, ADR_CTRL, AUD | ON);
		rnd = xs(rnd);
		w = rnd[7:0];
		wb(1, ADR_DATA, rnd);
		rnd = xs(rnd);
		peer.xfer(1, rnd[7:0], got);
		chk("sdo_word", w, got);
		idle(10);
		wb(0, ADR_DATA, 0);
		chk("rx_data", rnd[7:0], rd[7:0]);
		$display("test audio done");
		results;
	end
endmodule

/* File: sbi_peer.sv */
`timescale 1ns/10ps
// ==========================================
// serial master model
module sbi_peer (
	// link towards the slave
	output logic      sck,
	output logic      ss_n,
	output logic      sdi,
	input  wire logic sdo,
	input  wire logic sdo_oe
);
	// idle: clock stands still, select high
	initial
	begin
		sck = 1'b0;
		ss_n = 1'b1;
		sdi = 1'b0;
	end

	// one word msb first, 48 ns period; sdo taken just before each lead edge
	task automatic xfer(input logic pol, input logic [7:0] mosi, output logic [7:0] miso);
		#1.3 sck = pol;
		#4 ss_n = 1'b0;
		#56;
		for (int i = 7; i >= 0; i--)
		begin
			sdi = mosi[i];
			#24 miso[i] = sdo_oe ? sdo : ~sdo;
			sck = ~pol;
			#24 sck = pol;
		end
		#24 ss_n = 1'b1;
		// released line shows the inverse, never a stale bit
		sdi = ~sdi;
	endtask
endmodule

/* File: sbi_pkg.sv */
package sbi_pkg;
	// ==========================================
	// geometry
	localparam int WORD_W     = 8;
	localparam int FIFO_DEPTH = 4;
	localparam int SYNC_W     = 3;

	// ==========================================
	// register byte offsets
	localparam logic [4:0] ADR_CTRL    = 5'h00;
	localparam logic [4:0] ADR_DATA    = 5'h04;
	localparam logic [4:0] ADR_STAT    = 5'h08;
	localparam logic [4:0] ADR_IRQ_ST  = 5'h0C;
	localparam logic [4:0] ADR_IRQ_CLR = 5'h10;
	localparam logic [4:0] ADR_IRQ_EN  = 5'h14;

	// ==========================================
	// control register fields
	localparam int CTL_FRM_BIT = 31;
	localparam int CTL_ON_BIT  = 15;
	localparam int CTL_AUD_BIT = 7;
	localparam int CTL_POL_BIT = 6;
	localparam int CTL_DIS_BIT = 4;
	localparam int CTL_TXS_LSB = 2;
	localparam int CTL_RXS_LSB = 0;

	// status register fields
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_TXC_LSB  = 8;
	localparam int STAT_RXC_LSB  = 16;

	// interrupt status bits
	localparam int IRQ_W       = 3;
	localparam int IRQ_TX_BIT  = 0;
	localparam int IRQ_RX_BIT  = 1;
	localparam int IRQ_OVF_BIT = 2;
	localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

	// interrupt select encodings
	localparam logic [1:0] SEL_3 = 2'h3;
	localparam logic [1:0] SEL_2 = 2'h2;
	localparam logic [1:0] SEL_1 = 2'h1;
	localparam logic [1:0] SEL_0 = 2'h0;

	// ==========================================
	// carriers
	typedef struct packed {
		logic       framed_mode_enable;
		logic       on;
		logic       audio_protocol_enable;
		logic       clock_polarity;
		logic       input_pin_disable;
		logic [1:0] tx_irq_select;
		logic [1:0] rx_irq_select;
	} sbi_ctrl_t;

	localparam sbi_ctrl_t CTRL_RST = '0;

	typedef struct packed {
		logic sck;
		logic ss_n;
		logic sdi;
	} sbi_link_t;

	typedef enum logic {SH_IDLE, SH_ACTIVE} sbi_sh_state_t;
endpackage

/* File: sbi_sync.sv */
`timescale 1ns/10ps
module sbi_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	// async in, synced out
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// ==========================================
	// two stages; the first is read only by the second
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= d_i;
			sync_q <= meta_q;
		end
	end

	assign q_o = sync_q;
endmodule
